//--- rtl/fbmc_seq.sv
// Command sequencer for key verify and user/field margin commands.
// Assumes an APB master at 250 MHz, one clock and asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module fbmc_seq #(
  parameter int BLOCKS = 4,
  parameter logic [6:0] BLOCK_BASE = 7'h7C
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic secured,
  output logic [2:0] read_level
);
  import fbmc_pkg::*;
  localparam int AW = (BLOCKS > 1) ? $clog2(BLOCKS) : 1;

  // Refuse block counts the 7-bit block field cannot address.
  initial
  begin
    if (BLOCKS < 1 || BLOCKS > 128 || 32'(BLOCK_BASE) + BLOCKS > 128)
    begin
      $error("fbmc_seq: BLOCKS/BLOCK_BASE out of range");
    end
  end

  fbmc_state_type state, next_state;
  logic [2:0] command_word_index, next_command_word_index;
  logic [15:0] command_word_array [5];
  logic [15:0] next_command_word_array [5];
  logic command_complete_flag, next_command_complete_flag;
  logic access_error_flag, next_access_error_flag;
  logic sec, next_sec;
  logic lockout, next_lockout;
  logic [1:0] backdoor_key_enable, next_backdoor_key_enable;
  logic [15:0] key_store [4];
  logic [15:0] next_key_store [4];
  logic special_mode, next_special_mode;
  logic [1:0] irq_status, next_irq_status;
  logic [1:0] irq_mask, next_irq_mask;
  logic [AW-1:0] read_sel, next_read_sel;
  fbmc_result_type result, next_result;
  logic [AW-1:0] target, next_target;
  logic [31:0] next_prdata;
  logic next_pslverr, next_irq, next_pready;
  logic setup, access, wr_en;
  logic [31:0] rd_word;
  logic addr_ok;
  logic [2:0] mem_rd_data;
  logic [6:0] blk_field;
  logic blk_ok;
  logic [15:0] level_word;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign blk_field = command_word_array[0][6:0];
  assign blk_ok = (blk_field >= BLOCK_BASE) && (32'(blk_field) < 32'(BLOCK_BASE) + BLOCKS);
  assign level_word = command_word_array[1];

  // Per-block margin level store.
  fbmc_level_mem #(
    .BLOCKS(BLOCKS),
    .AW(AW)
  ) u_level_mem (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(wr_en),
    .wr_addr(target),
    .wr_data(level_word[2:0]),
    .rd_addr(read_sel),
    .rd_data(mem_rd_data)
  );

  // Read decoder: the word shown at each address, and whether the address is mapped.
  always_comb
  begin
    rd_word = 32'h00000000;
    addr_ok = 1'b1;
    unique case (paddr)
      FBMC_OFF_CMD_INDEX: rd_word = {29'h0, command_word_index};
      FBMC_OFF_CMD_WORD: rd_word = (command_word_index <= FBMC_IDX_KEY_LAST) ?
        {16'h0, command_word_array[command_word_index]} : 32'h00000000;
      FBMC_OFF_STATUS:
      begin
        // Protection and verify-failure bits are never raised by these commands.
        rd_word[FBMC_BIT_COMPLETE] = command_complete_flag;
        rd_word[FBMC_BIT_ACCESS_ERROR_FLAG] = access_error_flag;
      end
      FBMC_OFF_SECURITY:
      begin
        rd_word[FBMC_BIT_SECURED] = sec;
        rd_word[FBMC_BIT_LOCKOUT] = lockout;
        rd_word[FBMC_BACKDOOR_KEY_ENABLE_LSB +: 2] = backdoor_key_enable;
      end
      FBMC_OFF_IRQ_STATUS: rd_word = {30'h0, irq_status};
      FBMC_OFF_IRQ_MASK: rd_word = {30'h0, irq_mask};
      FBMC_OFF_MODE: rd_word = {31'h0, special_mode};
      FBMC_OFF_MARGIN: rd_word = {13'h0, mem_rd_data, 16'h0 | 16'(read_sel)};
      FBMC_OFF_KEY_BASE, FBMC_OFF_KEY_BASE + 8'h04, FBMC_OFF_KEY_BASE + 8'h08,
      FBMC_OFF_KEY_BASE + 8'h0C: rd_word = {16'h0, key_store[paddr[3:2]]};
      default: addr_ok = 1'b0;
    endcase
  end

  // Bus slave, register writes, command checking and completion.
  always_comb
  begin
    next_state = state;
    next_command_word_index = command_word_index;
    next_command_word_array = command_word_array;
    next_command_complete_flag = command_complete_flag;
    next_access_error_flag = access_error_flag;
    next_sec = sec;
    next_lockout = lockout;
    next_backdoor_key_enable = backdoor_key_enable;
    next_key_store = key_store;
    next_special_mode = special_mode;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_read_sel = read_sel;
    next_result = result;
    next_target = target;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    next_pready = setup;
    wr_en = 1'b0;
    // Read data and the error answer are registered in the setup cycle, so both
    // stand at the access edge beside pready.
    if (setup)
    begin
      next_pslverr = !addr_ok;
      if (!pwrite)
      begin
        next_prdata = rd_word;
      end
    end
    // A read of the interrupt status clears only the bits that it showed, so an
    // event that lands during the transfer is not lost.
    if (access && !pwrite && paddr == FBMC_OFF_IRQ_STATUS)
    begin
      next_irq_status = irq_status & ~prdata[1:0];
    end
    // Register writes; command registers are frozen while a command runs.
    if (access && pwrite)
    begin
      unique case (paddr)
        FBMC_OFF_CMD_INDEX:
          if (command_complete_flag) next_command_word_index = pwdata[2:0];
        FBMC_OFF_CMD_WORD:
          if (command_complete_flag && command_word_index <= FBMC_IDX_KEY_LAST)
            next_command_word_array[command_word_index] = pwdata[15:0];
        FBMC_OFF_STATUS:
        begin
          if (pwdata[FBMC_BIT_ACCESS_ERROR_FLAG]) next_access_error_flag = 1'b0;
          // Writing one to the complete flag clears it and launches, unless the access error flag is still set.
          if (pwdata[FBMC_BIT_COMPLETE] && command_complete_flag && !access_error_flag)
          begin
            next_command_complete_flag = 1'b0;
            next_state = FBMC_CHECK;
          end
        end
        FBMC_OFF_SECURITY: next_backdoor_key_enable = pwdata[FBMC_BACKDOOR_KEY_ENABLE_LSB +: 2];
        FBMC_OFF_IRQ_STATUS: ;
        FBMC_OFF_IRQ_MASK: next_irq_mask = pwdata[1:0];
        FBMC_OFF_MODE: next_special_mode = pwdata[0];
        FBMC_OFF_MARGIN: next_read_sel = pwdata[AW-1:0];
        FBMC_OFF_KEY_BASE, FBMC_OFF_KEY_BASE + 8'h04, FBMC_OFF_KEY_BASE + 8'h08,
        FBMC_OFF_KEY_BASE + 8'h0C: next_key_store[paddr[3:2]] = pwdata[15:0];
        default: ;
      endcase
    end
    // Sequencer.
    unique case (state)
      FBMC_IDLE: ;
      FBMC_CHECK:
      begin
        next_result = '0;
        next_target = AW'(blk_field - BLOCK_BASE);
        next_state = FBMC_FINISH;
        unique case (command_word_array[0][15:8])
          FBMC_OP_KEY_VERIFY:
          begin
            if (command_word_index != FBMC_IDX_KEY_LAST) next_result.error = 1'b1;
            else if (backdoor_key_enable != FBMC_BACKDOOR_KEY_ENABLE_ON) next_result.error = 1'b1;
            else if (lockout) next_result.error = 1'b1;
            else next_state = FBMC_COMPARE;
          end
          FBMC_OP_USER_MARGIN:
          begin
            if (command_word_index != FBMC_IDX_MARGIN_LAST || !blk_ok ||
                level_word > FBMC_LVL_USER_MAX) next_result.error = 1'b1;
            else next_result.write_level = 1'b1;
          end
          FBMC_OP_FIELD_MARGIN:
          begin
            if (command_word_index != FBMC_IDX_MARGIN_LAST || !special_mode || !blk_ok ||
                level_word > FBMC_LVL_FIELD_MAX) next_result.error = 1'b1;
            else next_result.write_level = 1'b1;
          end
          default: next_result.error = 1'b1;
        endcase
      end
      FBMC_COMPARE:
      begin
        next_state = FBMC_FINISH;
        // Key n pairs with the stored word n above the key address.
        if (command_word_array[1] == key_store[0] && command_word_array[2] == key_store[1] &&
            command_word_array[3] == key_store[2] && command_word_array[4] == key_store[3])
          next_result.release_sec = 1'b1;
        else
        begin
          next_result.error = 1'b1;
          next_result.lock = 1'b1;
        end
      end
      FBMC_FINISH:
      begin
        wr_en = result.write_level;
        if (result.release_sec) next_sec = 1'b0;
        if (result.lock) next_lockout = 1'b1;
        if (result.error) next_access_error_flag = 1'b1;
        next_command_complete_flag = 1'b1;
        next_irq_status[FBMC_IRQ_DONE] = 1'b1;
        if (result.error) next_irq_status[FBMC_IRQ_ERR] = 1'b1;
        next_state = FBMC_IDLE;
      end
      default: next_state = FBMC_IDLE;
    endcase
    next_irq = |(next_irq_status & irq_mask);
  end

  // State registers.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= FBMC_IDLE;
      command_word_index <= 3'h0;
      for (int i = 0; i < 5; i++) command_word_array[i] <= 16'h0000;
      for (int i = 0; i < 4; i++) key_store[i] <= FBMC_KEY_RESET[16*i +: 16];
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      sec <= 1'b1;
      lockout <= 1'b0;
      backdoor_key_enable <= FBMC_BACKDOOR_KEY_ENABLE_RESET;
      special_mode <= 1'b0;
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      read_sel <= '0;
      result <= '0;
      target <= '0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      command_word_index <= next_command_word_index;
      command_word_array <= next_command_word_array;
      key_store <= next_key_store;
      command_complete_flag <= next_command_complete_flag;
      access_error_flag <= next_access_error_flag;
      sec <= next_sec;
      lockout <= next_lockout;
      backdoor_key_enable <= next_backdoor_key_enable;
      special_mode <= next_special_mode;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      read_sel <= next_read_sel;
      result <= next_result;
      target <= next_target;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // Ready is registered from the setup cycle, so every access completes with no wait cycle.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      secured <= 1'b1;
      read_level <= FBMC_LVL_NORMAL;
    end
    else
    begin
      pready <= next_pready;
      secured <= next_sec;
      read_level <= mem_rd_data;
    end
  end
endmodule // fbmc_seq
`default_nettype wire

//--- rtl/fbmc_pkg.sv
// Package for the flash backdoor-key and margin-level command sequencer.
// Assumes a 32-bit APB slave at 250 MHz and a single clock domain.
package fbmc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] FBMC_OFF_CMD_INDEX = 8'h00;
  localparam logic [7:0] FBMC_OFF_CMD_WORD = 8'h04;
  localparam logic [7:0] FBMC_OFF_STATUS = 8'h08;
  localparam logic [7:0] FBMC_OFF_SECURITY = 8'h0C;
  localparam logic [7:0] FBMC_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] FBMC_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] FBMC_OFF_MODE = 8'h18;
  localparam logic [7:0] FBMC_OFF_MARGIN = 8'h1C;
  localparam logic [7:0] FBMC_OFF_KEY_BASE = 8'h20;
  // Status register bit positions.
  localparam int FBMC_BIT_COMPLETE = 7;
  localparam int FBMC_BIT_ACCESS_ERROR_FLAG = 5;
  localparam int FBMC_BIT_PROT = 4;
  localparam int FBMC_BIT_VERIFY_ERR = 1;
  localparam int FBMC_BIT_UNCORR_ERR = 0;
  // Security register bit positions.
  localparam int FBMC_BIT_SECURED = 0;
  localparam int FBMC_BIT_LOCKOUT = 1;
  localparam int FBMC_BACKDOOR_KEY_ENABLE_LSB = 6;
  // Interrupt status bit positions.
  localparam int FBMC_IRQ_DONE = 0;
  localparam int FBMC_IRQ_ERR = 1;
  // Opcodes, indices and values.
  localparam logic [7:0] FBMC_OP_KEY_VERIFY = 8'h0C;
  localparam logic [7:0] FBMC_OP_USER_MARGIN = 8'h0D;
  localparam logic [7:0] FBMC_OP_FIELD_MARGIN = 8'h0E;
  localparam logic [2:0] FBMC_IDX_KEY_LAST = 3'h4;
  localparam logic [2:0] FBMC_IDX_MARGIN_LAST = 3'h1;
  localparam logic [1:0] FBMC_BACKDOOR_KEY_ENABLE_ON = 2'h2;
  localparam logic [15:0] FBMC_LVL_USER_MAX = 16'h0002;
  localparam logic [15:0] FBMC_LVL_FIELD_MAX = 16'h0004;
  localparam logic [22:0] FBMC_KEY_ADDR = 23'h7FFF00;
  localparam logic [2:0] FBMC_LVL_NORMAL = 3'h0;
  localparam logic [1:0] FBMC_BACKDOOR_KEY_ENABLE_RESET = 2'h2;
  localparam logic [63:0] FBMC_KEY_RESET = 64'h0123456789ABCDEF;
  // Sequencer states.
  typedef enum logic [3:0] {
    FBMC_IDLE = 4'b0001,
    FBMC_CHECK = 4'b0010,
    FBMC_COMPARE = 4'b0100,
    FBMC_FINISH = 4'b1000
  } fbmc_state_type;
  // Result of one command, passed to the finishing step.
  typedef struct packed {
    logic error;
    logic release_sec;
    logic lock;
    logic write_level;
  } fbmc_result_type;
endpackage

//--- rtl/fbmc_level_mem.sv
// Small memory holding one margin level per flash block.
// Assumes one clock; the read data come out of a register.
`timescale 1ns/1ns
`default_nettype none
module fbmc_level_mem #(
  parameter int BLOCKS = 4,
  parameter int AW = 2
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [2:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [2:0] rd_data
);
  import fbmc_pkg::*;
  logic [2:0] level [BLOCKS];
  logic [2:0] next_level [BLOCKS];
  logic [2:0] next_rd_data;

  // Reject an address width too narrow for the block count.
  initial
  begin
    if (BLOCKS > (1 << AW) || BLOCKS < 1)
    begin
      $error("fbmc_level_mem: BLOCKS does not fit AW");
    end
  end

  // Next levels and registered read port.
  always_comb
  begin
    next_level = level;
    if (wr_en)
    begin
      next_level[wr_addr] = wr_data;
    end
    next_rd_data = (32'(rd_addr) < BLOCKS) ? level[rd_addr] : FBMC_LVL_NORMAL;
  end

  // Levels return to normal reads on reset.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < BLOCKS; i++)
      begin
        level[i] <= FBMC_LVL_NORMAL;
      end
      rd_data <= FBMC_LVL_NORMAL;
    end
    else
    begin
      level <= next_level;
      rd_data <= next_rd_data;
    end
  end
endmodule // fbmc_level_mem
`default_nettype wire

//--- sim/fbmc_seq_sva.sv
// Checker for the flash command sequencer; it watches only the top ports.
// Assumes one clock and an asynchronous active-low reset; bound below.
`timescale 1ns/1ns
`default_nettype none
module fbmc_seq_sva
  import fbmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic secured,
  input wire logic [2:0] read_level
);
  logic launch;
  logic rd_stat;
  logic [3:0] since;
  logic [3:0] next_since;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Decode a launch write and a status read at their access edges.
  assign launch = psel && penable && pready && pwrite && paddr == FBMC_OFF_STATUS && pwdata[7];
  assign rd_stat = psel && penable && pready && !pwrite && paddr == FBMC_OFF_STATUS;
  // Count cycles since the last launch, saturating so it never wraps.
  always_comb
  begin
    next_since = since;
    if (launch)
      next_since = 4'h0;
    else if (since != 4'hF)
      next_since = since + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      since <= 4'hF;
    else
      since <= next_since;
  end
  // Bus handshake, error reporting and the outcome of the commands.
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h2C |-> pslverr)
    else $error("unmapped access not refused");
  AST_STATUS_ZERO_BITS: assert property (rd_stat |-> prdata[4:0] ==? 5'b0??00)
    else $error("forbidden status bit set");
  AST_COMPLETE_BACK: assert property (rd_stat && since > 4'h7 |-> prdata[7])
    else $error("complete flag not back");
  AST_SECURE_HOLD: assert property (!secured |=> !secured)
    else $error("security engaged again without reset");
  AST_SECURE_CAUSE: assert property ($fell(secured) |-> since < 4'h8)
    else $error("security released without a command");
  AST_LEVEL_RANGE: assert property (read_level <= 3'h4)
    else $error("margin level out of range");
  COV_LAUNCH: cover property (launch);
  COV_RELEASE: cover property ($fell(secured));
  COV_REFUSE: cover property (pslverr);
endmodule // fbmc_seq_sva
bind fbmc_seq fbmc_seq_sva i_fbmc_seq_sva (.sys_clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .secured, .read_level);
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the flash backdoor-key and margin command sequencer.
// Assumes the register map and no-wait APB timing of the sequencer package.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fbmc_pkg::*;
  typedef struct packed {
    logic spec;
    logic [7:0] op;
    logic [6:0] blk;
    logic [15:0] lv;
    logic [2:0] li;
    logic e;
  } fbmc_row_type;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, secured, se;
  logic [2:0] read_level;
  logic [2:0] lvl [4] = '{default: 3'h0};
  logic [15:0] cw [5];
  int n_errors = 0;
  int tests_run = 0;
  // Mode, opcode, block, setting, launch index, expected error.
  fbmc_row_type rows [13] = '{
    '{1'b0, 8'h0D, 7'h7C, 16'h0001, 3'h1, 1'b0}, '{1'b0, 8'h0D, 7'h7D, 16'h0002, 3'h1, 1'b0},
    '{1'b0, 8'h0D, 7'h7C, 16'h0000, 3'h1, 1'b0}, '{1'b0, 8'h0D, 7'h7F, 16'h0003, 3'h1, 1'b1},
    '{1'b0, 8'h0D, 7'h7E, 16'h0001, 3'h2, 1'b1}, '{1'b0, 8'h0D, 7'h7B, 16'h0001, 3'h1, 1'b1},
    '{1'b0, 8'h0E, 7'h7F, 16'h0003, 3'h1, 1'b1}, '{1'b1, 8'h0E, 7'h7F, 16'h0003, 3'h1, 1'b0},
    '{1'b1, 8'h0E, 7'h7E, 16'h0004, 3'h1, 1'b0}, '{1'b1, 8'h0E, 7'h7D, 16'h0005, 3'h1, 1'b1},
    '{1'b1, 8'h0E, 7'h7C, 16'h0002, 3'h1, 1'b0}, '{1'b1, 8'h0F, 7'h7C, 16'h0001, 3'h1, 1'b1},
    '{1'b1, 8'h0E, 7'h7C, 16'h0001, 3'h0, 1'b1}};
  // The 250 MHz clock.
  always #2 sys_clk = ~sys_clk;
  fbmc_seq i_fbmc_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .secured(secured),
    .read_level(read_level)
  );
  // Count a comparison and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Load words 0..n, set the launch index, launch, wait and check the status.
  task automatic cmd(input int n, input logic [2:0] li, input logic e);
    int k;
    for (int i = 0; i <= n; i++)
    begin
      apb(1'b1, FBMC_OFF_CMD_INDEX, 32'(i));
      apb(1'b1, FBMC_OFF_CMD_WORD, {16'h0, cw[i]});
    end
    apb(1'b1, FBMC_OFF_CMD_INDEX, {29'h0, li});
    apb(1'b1, FBMC_OFF_STATUS, 32'h80);
    k = 0;
    do
    begin
      apb(1'b0, FBMC_OFF_STATUS, 32'h0);
      k++;
    end
    while (rd[7] !== 1'b1 && k < 10);
    chk(rd & 32'hB3, e ? 32'hA0 : 32'h80);
    apb(1'b1, FBMC_OFF_STATUS, 32'h20);
  endtask
  // Select a block, then compare its level on the bus and on the level output.
  task automatic lvchk(input logic [6:0] b);
    apb(1'b1, FBMC_OFF_MARGIN, {25'h0, b});
    apb(1'b0, FBMC_OFF_MARGIN, 32'h0);
    chk({29'h0, rd[18:16]}, {29'h0, lvl[b[1:0]]});
    chk({29'h0, read_level}, {29'h0, lvl[b[1:0]]});
  endtask
  // Pulse reset for two clock cycles.
  task automatic do_reset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask
  // Print the counts and the verdict, then stop.
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // The run needs under a thousand cycles; cut a hang at 25000.
  initial
  begin
    #100000;
    n_errors++;
    final_report;
  end
  // Main sequence: reset values, margin table, interrupts, key verify.
  initial
  begin
    do_reset;
    apb(1'b0, FBMC_OFF_STATUS, 32'h0);
    chk(rd & 32'hB3, 32'h80);
    apb(1'b0, FBMC_OFF_SECURITY, 32'h0);
    chk(rd & 32'hC3, 32'h81);
    apb(1'b1, FBMC_OFF_IRQ_MASK, 32'h3);
    for (int r = 0; r < 13; r++)
    begin
      apb(1'b1, FBMC_OFF_MODE, {31'h0, rows[r].spec});
      cw[0] = {rows[r].op, 1'b0, rows[r].blk};
      cw[1] = rows[r].lv;
      cmd(1, rows[r].li, rows[r].e);
      if (!rows[r].e)
        lvl[rows[r].blk[1:0]] = rows[r].lv[2:0];
      if (rows[r].blk >= 7'h7C)
        lvchk(rows[r].blk);
    end
    // Unmapped address refused, interrupt raised, cleared and masked.
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, FBMC_OFF_IRQ_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b0, FBMC_OFF_IRQ_MASK, 32'h0);
    chk({30'h0, se, irq}, 32'h0);
    apb(1'b1, FBMC_OFF_IRQ_MASK, 32'h0);
    cmd(1, 3'h1, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, FBMC_OFF_IRQ_MASK, 32'h1);
    apb(1'b0, FBMC_OFF_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h1);
    // Key verify: disabled, wrong index, mismatch, lockout, then reset.
    cw = '{16'h0C00, 16'hCDEF, 16'h89AB, 16'h4567, 16'h0123};
    apb(1'b1, FBMC_OFF_SECURITY, 32'h40);
    cmd(4, 3'h4, 1'b1);
    apb(1'b1, FBMC_OFF_SECURITY, 32'h80);
    cmd(4, 3'h3, 1'b1);
    cw[2] = 16'h89AA;
    cmd(4, 3'h4, 1'b1);
    apb(1'b0, FBMC_OFF_SECURITY, 32'h0);
    chk(rd & 32'h3, 32'h3);
    cw[2] = 16'h89AB;
    cmd(4, 3'h4, 1'b1);
    chk({31'h0, secured}, 32'h1);
    do_reset;
    lvl = '{default: 3'h0};
    lvchk(7'h7E);
    cmd(4, 3'h4, 1'b0);
    chk({31'h0, secured}, 32'h0);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
